//--- verilog/clk_ctrl_defs.vh
// Offsets, fields, reset values and timing counts of the clock controller
`ifndef CLK_CTRL_DEFS_VH
`define CLK_CTRL_DEFS_VH

// Register byte offsets
`define OFS_SYSSEL      8'h00
`define OFS_PRESCALE    8'h04
`define OFS_LOCK        8'h08
`define OFS_OSC_EN      8'h0c
`define OFS_STATUS      8'h10
`define OFS_PLL_CFG     8'h14
`define OFS_MONITOR     8'h18
`define OFS_PROTECT     8'h1c
`define OFS_DFLL0_CFG   8'h20
`define OFS_DFLL0_CAL   8'h24
`define FREQ_LOCK_CALIBRATOR_STRIDE     8'h08

// System clock source codes
`define SRC_RC2         3'h0
`define SRC_RC32        3'h1
`define SRC_RC32K       3'h2
`define SRC_EXT         3'h3
`define SRC_PLL         3'h4

// Field positions
`define PS_A_MSB        6
`define PS_A_LSB        2
`define MON_EXT_BIT     0
`define MON_PLL_BIT     1
`define FAIL_EXT_BIT    2
`define FAIL_PLL_BIT    3
`define CAL_COMP_LSB    16

// Reset values and first-stage code limit
`define OSC_EN_RESET    5'h01
`define MULTIPLIER_FACTOR_RESET   5'h01
`define PSA_MAX_CODE    5'h11
`define CAL_RESET       7'h40
`define COMP0_RESET     16'h07a1
`define COMP1_RESET     16'h7a12

// Unlock key and timing
`define UNLOCK_KEY      8'h5a
`define UNLOCK_CYCLES   3'h4
`define SWITCH_EDGES    2'h2
`define FREQ_LOCK_CALIBRATOR_REF_LAST   5'h1f
`define FREQ_LOCK_CALIBRATOR_HALF_STEP  16'h0008

`endif

//--- verilog/clock_prescaler.v
// Three-stage prescaler producing phase-aligned derived clock enables
module clock_prescaler (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Selected system clock tick and requested settings
  input  wire       sys_tick,
  input  wire [4:0] psa_code,
  input  wire [1:0] psbc_code,
  // Derived clock ticks
  output reg        tick_x4,
  output reg        tick_x2,
  output reg        tick_cpu
);

  reg  [3:0] a_shift;
  reg  [1:0] bc_code;
  reg  [8:0] a_cnt;
  reg  [1:0] bc_cnt;
  wire [8:0] a_lim   = ~(9'h1ff << a_shift);
  wire       a_end   = sys_tick && (a_cnt == a_lim);
  // Period of x2 and cpu ticks counted in x4 ticks, minus one
  wire [1:0] b_lim   = (bc_code == 2'h2) ? 2'h3 :
                       (bc_code == 2'h3) ? 2'h1 : 2'h0;
  wire [1:0] bc_lim  = (bc_code == 2'h0) ? 2'h0 :
                       (bc_code == 2'h1) ? 2'h1 : 2'h3;
  wire       cpu_end = a_end && (bc_cnt == bc_lim);
  wire [3:0] new_shift = (psa_code == 5'h00) ? 4'h0 :
                         (psa_code[4:1] + 4'h1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_shift  <= 4'h0;
      bc_code  <= 2'h0;
      a_cnt    <= 9'h000;
      bc_cnt   <= 2'h0;
      tick_x4  <= 1'b0;
      tick_x2  <= 1'b0;
      tick_cpu <= 1'b0;
    end else begin
      tick_x4  <= a_end;
      tick_x2  <= a_end && ((bc_cnt & b_lim) == b_lim);
      tick_cpu <= cpu_end;
      if (sys_tick)
        a_cnt <= a_end ? 9'h000 : a_cnt + 9'h001;
      if (a_end)
        bc_cnt <= (bc_cnt == bc_lim) ? 2'h0 : bc_cnt + 2'h1;
      // All counters wrap together here, so a swap keeps phases aligned
      if (cpu_end) begin
        a_shift <= new_shift;
        bc_code <= psbc_code;
      end
    end
  end

endmodule // clock_prescaler

//--- verilog/system_clock_control.v
// System clock controller: source switch, prescalers, PLL, loops, monitor
// Behaviour
// - Refuse unstable source; keep current source enabled
// - Ready flag readable for every oscillator
// - First stage divides by 1 to 512
// - Second and third stages pass or divide
// - Derived clocks phase aligned, glitch free
// - New prescale applied on slowest clock edge
// - Protected settings need timed unlock write
// - PLL output equals reference times factor
// - PLL reference chosen among four sources
// - PLL config writes ignored while enabled
// - PLL usable only when reference stable, locked
// - PLL reference cannot be disabled by software while enabled
// - Loop reference divided by 32
// - Compare loaded at reset; fast loop writable
// - Calibration steps by one on half-step error
// - Loop halts in sleep, keeps value
// - Failure of system source: fallback, flag, NMI
// - Failure of idle source: just disable it
// - Monitor enable sticks until reset
// - Monitor paused in sleep
// - Switch takes two old, two new edges
// - Source selection codes
// - First-stage ratio codes
// - Second and third stage ratio codes
`include "clk_ctrl_defs.vh"

module system_clock_control #(
  parameter LOOPS = 2
) (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Oscillators: rc2, rc32, rc32k, external; tick bit 4 is the PLL
  input  wire [3:0]  osc_ready,
  input  wire [4:0]  osc_tick,
  input  wire        pll_locked,
  input  wire        ext_stopped,
  input  wire        sleep_stop,
  // Loop references: rc32k, crystal, external clock, start of frame
  input  wire [3:0]  freq_lock_calibrator_ref_tick,
  // Oscillator and PLL control
  output reg  [4:0]  osc_enable,
  output reg  [4:0]  multiplier_factor,
  output reg  [1:0]  pll_ref_select,
  output reg  [6:0]  cal_2m,
  output reg  [6:0]  cal_32m,
  // Clocks as enable ticks
  output reg  [2:0]  sysclk_source_select,
  output reg         system_clock,
  output wire        periph_clock_x4,
  output wire        periph_clock_x2,
  output wire        cpu_clock,
  output reg         nmi
);

  localparam ST_IDLE = 2'h0;
  localparam ST_OLD  = 2'h1;
  localparam ST_NEW  = 2'h2;

  reg  [2:0]  next_sel;
  reg  [1:0]  sw_state;
  reg  [1:0]  sw_cnt;
  reg         cfg_lock;
  reg  [2:0]  unlock_cnt;
  reg  [4:0]  first_stage_ratio;
  reg  [1:0]  second_third_stage_ratio;
  reg         mon_ext;
  reg         mon_pll;
  reg         fail_ext;
  reg         fail_pll;
  reg         pll_locked_d;
  reg  [31:0] rd_mux;
  reg         rd_hit;
  wire [6:0]  cal_all [0:LOOPS-1];

  wire access = psel && penable;
  wire wr     = access && pready && pwrite;
  wire prot   = (unlock_cnt != 3'h0);
  wire busy   = (sw_state != ST_IDLE);

  // PLL reference index into the oscillator enable vector
  wire [2:0] ref_idx = (pll_ref_select == 2'h0) ? `SRC_RC2  :
                       (pll_ref_select == 2'h1) ? `SRC_RC32 : `SRC_EXT;
  wire ref_ok = osc_enable[ref_idx] && osc_ready[ref_idx[1:0]];
  wire pll_ok = osc_enable[4] && ref_ok && pll_locked;
  wire [4:0] ready = {pll_ok, osc_ready & osc_enable[3:0]};

  // Bits software may not clear
  wire [4:0] keep = (5'h01 << sysclk_source_select) |
                    (busy ? (5'h01 << next_sel) : 5'h00) |
                    (osc_enable[4] ? (5'h01 << ref_idx)
                                   : 5'h00);

  wire [2:0] want = pwdata[2:0];
  wire sel_ok = (want <= `SRC_PLL) && ready[want] &&
                (want != sysclk_source_select) && !busy;
  wire [4:0] ps_a = pwdata[`PS_A_MSB:`PS_A_LSB];
  wire ps_ok = (ps_a == 5'h00) ||
               (ps_a[0] && (ps_a <= `PSA_MAX_CODE));

  // Monitor runs only while awake; is left to software
  wire mon_live = !sleep_stop;
  wire ext_bad  = mon_live && mon_ext && osc_enable[3] && ext_stopped;
  wire pll_bad  = mon_live && mon_pll && osc_enable[4] &&
                  pll_locked_d && !pll_locked;
  wire ext_sys  = (sysclk_source_select == `SRC_EXT) ||
                  (busy && next_sel == `SRC_EXT);
  wire pll_sys  = (sysclk_source_select == `SRC_PLL) ||
                  (busy && next_sel == `SRC_PLL);
  wire sys_fail = (ext_bad && ext_sys) || (pll_bad && pll_sys);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysclk_source_select     <= `SRC_RC2;
      next_sel                 <= `SRC_RC2;
      sw_state                 <= ST_IDLE;
      sw_cnt                   <= 2'h0;
      osc_enable               <= `OSC_EN_RESET;
      multiplier_factor        <= `MULTIPLIER_FACTOR_RESET;
      pll_ref_select           <= 2'h0;
      cfg_lock                 <= 1'b0;
      unlock_cnt               <= 3'h0;
      first_stage_ratio        <= 5'h00;
      second_third_stage_ratio <= 2'h0;
      mon_ext                  <= 1'b0;
      mon_pll                  <= 1'b0;
      fail_ext                 <= 1'b0;
      fail_pll                 <= 1'b0;
      nmi                      <= 1'b0;
      pll_locked_d             <= 1'b0;
      system_clock             <= 1'b0;
    end else begin
      nmi          <= 1'b0;
      pll_locked_d <= pll_locked;
      // Held quiet while a switch is in progress
      system_clock <= !busy && osc_tick[sysclk_source_select];
      if (prot)
        unlock_cnt <= unlock_cnt - 3'h1;
      case (sw_state)
        ST_OLD: begin
          if (osc_tick[sysclk_source_select]) begin
            sw_cnt <= sw_cnt + 2'h1;
            if (sw_cnt + 2'h1 == `SWITCH_EDGES) begin
              sw_cnt   <= 2'h0;
              sw_state <= ST_NEW;
            end
          end
        end
        ST_NEW: begin
          if (osc_tick[next_sel]) begin
            sw_cnt <= sw_cnt + 2'h1;
            if (sw_cnt + 2'h1 == `SWITCH_EDGES) begin
              sw_cnt               <= 2'h0;
              sw_state             <= ST_IDLE;
              sysclk_source_select <= next_sel;
            end
          end
        end
        default: sw_state <= ST_IDLE;
      endcase
      if (wr) begin
        case (paddr)
          `OFS_PROTECT:
            if (pwdata[7:0] == `UNLOCK_KEY)
              unlock_cnt <= `UNLOCK_CYCLES;
          `OFS_SYSSEL: begin
            unlock_cnt <= 3'h0;
            if (prot && !cfg_lock && sel_ok) begin
              next_sel <= want;
              sw_state <= ST_OLD;
            end
          end
          `OFS_PRESCALE: begin
            unlock_cnt <= 3'h0;
            if (prot && !cfg_lock && ps_ok) begin
              first_stage_ratio        <= ps_a;
              second_third_stage_ratio <= pwdata[1:0];
            end
          end
          `OFS_LOCK: begin
            unlock_cnt <= 3'h0;
            if (prot && pwdata[0])
              cfg_lock <= 1'b1;
          end
          `OFS_MONITOR: begin
            unlock_cnt <= 3'h0;
            if (prot) begin
              mon_ext <= mon_ext | pwdata[`MON_EXT_BIT];
              mon_pll <= mon_pll | pwdata[`MON_PLL_BIT];
            end
            if (pwdata[`FAIL_EXT_BIT])
              fail_ext <= 1'b0;
            if (pwdata[`FAIL_PLL_BIT])
              fail_pll <= 1'b0;
          end
          `OFS_OSC_EN:
            osc_enable <= pwdata[4:0] | keep;
          `OFS_PLL_CFG:
            // Reconfiguring a running PLL would glitch its output
            if (!osc_enable[4]) begin
              multiplier_factor <= pwdata[4:0];
              pll_ref_select    <= pwdata[6:5];
            end
          default: ;
        endcase
      end
      // Failure handling comes last so it overrides any write
      if (ext_bad && ext_sys)
        fail_ext <= 1'b1;
      if (pll_bad && pll_sys)
        fail_pll <= 1'b1;
      if (sys_fail) begin
        sysclk_source_select <= `SRC_RC2;
        next_sel             <= `SRC_RC2;
        sw_state             <= ST_IDLE;
        sw_cnt               <= 2'h0;
        osc_enable           <= `OSC_EN_RESET;
        nmi                  <= 1'b1;
      end else begin
        if (ext_bad)
          osc_enable[3] <= 1'b0;
        if (pll_bad)
          osc_enable[4] <= 1'b0;
      end
    end
  end

  clock_prescaler u_prescaler (
    .pclk      (pclk),
    .presetn   (presetn),
    .sys_tick  (system_clock),
    .psa_code  (first_stage_ratio),
    .psbc_code (second_third_stage_ratio),
    .tick_x4   (periph_clock_x4),
    .tick_x2   (periph_clock_x2),
    .tick_cpu  (cpu_clock)
  );

  // Calibration loops: loop 0 trims the 2MHz, loop 1 the 32MHz oscillator
  genvar i;
  generate
    for (i = 0; i < LOOPS; i = i + 1) begin : g_loop
      localparam [31:0] CFG_A = `OFS_DFLL0_CFG + `FREQ_LOCK_CALIBRATOR_STRIDE * i;
      localparam [31:0] CAL_A = `OFS_DFLL0_CAL + `FREQ_LOCK_CALIBRATOR_STRIDE * i;
      reg        en;
      reg  [1:0] ref_sel;
      reg  [6:0] cal;
      reg  [15:0] comp;
      reg  [15:0] osc_cnt;
      reg  [4:0] ref_cnt;
      wire       run   = en && !sleep_stop;
      wire       rtick = freq_lock_calibrator_ref_tick[ref_sel];
      wire [16:0] hi   = {1'b0, comp} + {1'b0, `FREQ_LOCK_CALIBRATOR_HALF_STEP};
      wire [16:0] cnt_hi = {1'b0, osc_cnt} + {1'b0, `FREQ_LOCK_CALIBRATOR_HALF_STEP};
      wire       fast  = ({1'b0, osc_cnt} > hi);
      wire       slow  = (cnt_hi < {1'b0, comp});
      assign cal_all[i] = cal;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          en      <= 1'b0;
          ref_sel <= 2'h0;
          cal     <= `CAL_RESET;
          comp    <= (i == 0) ? `COMP0_RESET : `COMP1_RESET;
          osc_cnt <= 16'h0000;
          ref_cnt <= 5'h00;
        end else begin
          if (wr && paddr == CFG_A[7:0]) begin
            en      <= pwdata[0];
            ref_sel <= pwdata[2:1];
          end
          if (wr && paddr == CAL_A[7:0]) begin
            if (!en)
              cal <= pwdata[6:0];
            if (i == 1)
              comp <= pwdata[31:16];
          end
          if (run) begin
            if (osc_tick[i] && osc_cnt != 16'hffff)
              osc_cnt <= osc_cnt + 16'h0001;
            if (rtick) begin
              ref_cnt <= ref_cnt + 5'h01;
              if (ref_cnt == `FREQ_LOCK_CALIBRATOR_REF_LAST) begin
                osc_cnt <= 16'h0000;
                if (fast && cal != 7'h00)
                  cal <= cal - 7'h01;
                else if (slow && cal != 7'h7f)
                  cal <= cal + 7'h01;
              end
            end
          end else if (!en) begin
            osc_cnt <= 16'h0000;
            ref_cnt <= 5'h00;
          end
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_2m  <= `CAL_RESET;
      cal_32m <= `CAL_RESET;
    end else begin
      cal_2m  <= cal_all[0];
      cal_32m <= cal_all[1];
    end
  end

  // Register read mux
  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      `OFS_SYSSEL:   rd_mux = {29'h0, sysclk_source_select};
      `OFS_PRESCALE: rd_mux = {25'h0, first_stage_ratio,
                               second_third_stage_ratio};
      `OFS_LOCK:     rd_mux = {31'h0, cfg_lock};
      `OFS_OSC_EN:   rd_mux = {27'h0, osc_enable};
      `OFS_STATUS:   rd_mux = {26'h0, busy, ready};
      `OFS_PLL_CFG:  rd_mux = {25'h0, pll_ref_select,
                               multiplier_factor};
      `OFS_MONITOR:  rd_mux = {28'h0, fail_pll, fail_ext,
                               mon_pll, mon_ext};
      `OFS_PROTECT:  rd_mux = {31'h0, prot};
      default: begin
        case (paddr)
          `OFS_DFLL0_CFG: rd_mux = {29'h0, g_loop[0].ref_sel, g_loop[0].en};
          `OFS_DFLL0_CAL: rd_mux = {g_loop[0].comp, 9'h000, g_loop[0].cal};
          `OFS_DFLL0_CFG + `FREQ_LOCK_CALIBRATOR_STRIDE:
            rd_mux = {29'h0, g_loop[1].ref_sel, g_loop[1].en};
          `OFS_DFLL0_CAL + `FREQ_LOCK_CALIBRATOR_STRIDE:
            rd_mux = {g_loop[1].comp, 9'h000, g_loop[1].cal};
          default: rd_hit = 1'b0;
        endcase
      end
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !rd_hit;
      if (access && !pready && !pwrite)
        prdata <= rd_mux;
    end
  end

endmodule // system_clock_control

//--- tb/clk_ctrl_monitor.sv
// Checker of source switching, PLL guard, 2MHz loop and failure handling
`include "clk_ctrl_defs.vh"

module clk_ctrl_monitor #(
  parameter LOOPS = 2
) (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Bus and oscillator inputs
  input wire logic       pready,
  input wire logic       pwrite,
  input wire logic       ext_stopped,
  input wire logic       pll_locked,
  input wire logic [4:0] osc_tick,
  // Controlled outputs
  input wire logic [4:0] osc_enable,
  input wire logic [4:0] multiplier_factor,
  input wire logic [1:0] pll_ref_select,
  input wire logic [6:0] cal_2m,
  input wire logic [2:0] sysclk_source_select,
  input wire logic       system_clock,
  input wire logic       periph_clock_x4,
  input wire logic       periph_clock_x2,
  input wire logic       cpu_clock,
  input wire logic       nmi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_on;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Crystal and external clock share one enable bit
  assign ref_on = (pll_ref_select == 2'h0) ? osc_enable[0] :
                  (pll_ref_select == 2'h1) ? osc_enable[1] : osc_enable[3];

  sequence fallback_pulse;
    nmi && sysclk_source_select == `SRC_RC2 &&
      osc_enable == `OSC_EN_RESET ##1 !nmi;
  endsequence

  a_src_kept_on: assert property (osc_enable[sysclk_source_select])
    else $error("current source oscillator is off");
  a_src_code_ok: assert property (sysclk_source_select <= `SRC_PLL)
    else $error("reserved source code in use");
  a_sys_follows: assert property (
    system_clock |-> $past(osc_tick[sysclk_source_select]))
    else $error("system clock tick without source tick");
  a_switch_quiet: assert property (
    $changed(sysclk_source_select) && !nmi |->
      $past(!system_clock) && $past(!system_clock, 2))
    else $error("system clock ticked during a switch");
  a_ticks_aligned: assert property (
    (cpu_clock |-> periph_clock_x2) and (periph_clock_x2 |-> periph_clock_x4))
    else $error("derived clocks out of phase");
  a_pll_frozen: assert property ($past(osc_enable[4]) |->
    $stable(multiplier_factor) && $stable(pll_ref_select))
    else $error("PLL setting changed while enabled");
  a_ref_kept: assert property ($past(osc_enable[4] && ref_on) |->
    ref_on || nmi || $past(ext_stopped))
    else $error("PLL reference turned off while PLL enabled");
  a_nmi_fallback: assert property (nmi |-> fallback_pulse)
    else $error("failure did not fall back to default source");
  a_nmi_cause: assert property (nmi |->
    $past(ext_stopped && osc_enable[3]) || $past(osc_enable[4] && !pll_locked))
    else $error("nmi without a source failure");
  a_cal_one_step: assert property ($changed(cal_2m) |->
    cal_2m == $past(cal_2m) + 7'h1 || cal_2m == $past(cal_2m) - 7'h1 ||
      $past(pready && pwrite, 2) || $past(pready && pwrite, 3))
    else $error("calibration moved by more than one step");
endmodule // clk_ctrl_monitor

bind system_clock_control clk_ctrl_monitor #(.LOOPS(LOOPS)) u_monitor (
  .pclk(pclk), .presetn(presetn), .pready(pready), .pwrite(pwrite),
  .ext_stopped(ext_stopped), .pll_locked(pll_locked), .osc_tick(osc_tick),
  .osc_enable(osc_enable), .multiplier_factor(multiplier_factor),
  .pll_ref_select(pll_ref_select), .cal_2m(cal_2m),
  .sysclk_source_select(sysclk_source_select), .system_clock(system_clock),
  .periph_clock_x4(periph_clock_x4), .periph_clock_x2(periph_clock_x2),
  .cpu_clock(cpu_clock), .nmi(nmi));

//--- tb/testbench.sv
// Self-checking testbench of the system clock controller
`include "clk_ctrl_defs.vh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic        pready, pslverr, rerr, pll_locked = 0, ext_stopped = 0;
  logic        sleep_stop = 0, system_clock, px4, px2, cpu, nmi;
  logic [3:0]  osc_ready = 4'h5, dref = 0;
  logic [4:0]  osc_tick = 0, osc_enable, mfac;
  logic [1:0]  pref;
  logic [6:0]  cal_2m, cal_32m;
  logic [2:0]  src;
  int          error_cnt = 0, tests_run = 0, cyc = 0, nmi_cnt = 0;
  int          s, f, h, i;

  system_clock_control #(.LOOPS(2)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_ready(osc_ready),
    .osc_tick(osc_tick), .pll_locked(pll_locked), .ext_stopped(ext_stopped),
    .sleep_stop(sleep_stop), .freq_lock_calibrator_ref_tick(dref), .osc_enable(osc_enable),
    .multiplier_factor(mfac), .pll_ref_select(pref), .cal_2m(cal_2m),
    .cal_32m(cal_32m), .sysclk_source_select(src),
    .system_clock(system_clock), .periph_clock_x4(px4),
    .periph_clock_x2(px2), .cpu_clock(cpu), .nmi(nmi));

  always #12.5 pclk = ~pclk;
  // Every source ticks on alternate cycles
  always @(posedge pclk) osc_tick <= ~osc_tick;
  always @(posedge pclk) begin
    cyc++;
    if (nmi === 1'b1)
      nmi_cnt++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Keeps psel up when rel is low so an unlock runs back to back
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic rel);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    penable <= 1'b0;
    if (rel) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b1);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b1);
    check(rdat, exp);
  endtask

  task uw(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, `OFS_PROTECT, {24'h0, `UNLOCK_KEY}, 1'b0);
    apb(1'b1, a, d, 1'b1);
  endtask

  task wsrc(input logic [2:0] c);
    for (i = 0; i < 60 && src !== c; i++)
      @(posedge pclk);
    check(src, c);
  endtask

  task cnt(input int k);
    int c;
    int g;
    c = 0;
    g = 0;
    s = 0;
    f = 0;
    h = 0;
    while (c < k && g < 5000) begin
      @(posedge pclk);
      g++;
      s += system_clock;
      f += px4;
      h += px2;
      c += cpu;
    end
  endtask

  task t_reset;
    rd(`OFS_SYSSEL, 32'h0);
    rd(`OFS_OSC_EN, 32'h1);
    rd(`OFS_PLL_CFG, 32'h1);
    rd(`OFS_STATUS, 32'h1);
    rd(`OFS_DFLL0_CAL, 32'h07a1_0040);
    rd(`OFS_DFLL0_CAL + `FREQ_LOCK_CALIBRATOR_STRIDE, 32'h7a12_0040);
    apb(1'b0, 8'hfc, 32'h0, 1'b1);
    check(rerr, 1'b1);
    $display("reset test done");
  endtask

  task t_switch;
    wr(`OFS_OSC_EN, 32'h03);
    uw(`OFS_SYSSEL, 32'h1);
    repeat (20) @(posedge pclk);
    check(src, `SRC_RC2);
    osc_ready <= 4'hf;
    wr(`OFS_SYSSEL, 32'h1);
    repeat (20) @(posedge pclk);
    check(src, `SRC_RC2);
    uw(`OFS_SYSSEL, 32'h5);
    repeat (20) @(posedge pclk);
    check(src, `SRC_RC2);
    uw(`OFS_SYSSEL, 32'h1);
    wsrc(`SRC_RC32);
    wr(`OFS_OSC_EN, 32'h0);
    check(osc_enable, 5'h02);
    $display("switch test done");
  endtask

  task automatic t_prescale;
    logic [6:0] code [5] = '{7'h00, 7'h05, 7'h0e, 7'h07, 7'h44};
    int da [5] = '{1, 2, 4, 2, 512};
    int q4 [5] = '{1, 2, 4, 4, 1};
    int q2 [5] = '{1, 2, 1, 2, 1};
    for (int n = 0; n < 5; n++) begin
      if (n == 4) begin
        uw(`OFS_PRESCALE, 32'h54);
        rd(`OFS_PRESCALE, 32'h07);
      end
      uw(`OFS_PRESCALE, {25'h0, code[n]});
      rd(`OFS_PRESCALE, {25'h0, code[n]});
      cnt(2);
      cnt(2);
      check(s, 2 * da[n] * q4[n]);
      check(f, 2 * q4[n]);
      check(h, 2 * q2[n]);
    end
    uw(`OFS_PRESCALE, 32'h0);
    $display("prescaler test done");
  endtask

  task t_pll;
    wr(`OFS_OSC_EN, 32'h03);
    for (int r = 0; r < 4; r++) begin
      wr(`OFS_PLL_CFG, r * 32 + 31 - r);
      check(pref, r);
      check(mfac, 31 - r);
    end
    wr(`OFS_PLL_CFG, 32'h1f);
    wr(`OFS_OSC_EN, 32'h13);
    wr(`OFS_PLL_CFG, 32'h25);
    check(mfac, 5'h1f);
    check(pref, 2'h0);
    wr(`OFS_OSC_EN, 32'h12);
    check(osc_enable, 5'h13);
    rd(`OFS_STATUS, 32'h03);
    uw(`OFS_SYSSEL, 32'h4);
    repeat (20) @(posedge pclk);
    check(src, `SRC_RC32);
    pll_locked <= 1'b1;
    rd(`OFS_STATUS, 32'h13);
    uw(`OFS_SYSSEL, 32'h4);
    wsrc(`SRC_PLL);
    uw(`OFS_MONITOR, 32'h2);
    pll_locked <= 1'b0;
    repeat (10) @(posedge pclk);
    check(nmi_cnt, 1);
    check(src, `SRC_RC2);
    check(osc_enable, 5'h01);
    rd(`OFS_MONITOR, 32'h0a);
    uw(`OFS_MONITOR, 32'h08);
    rd(`OFS_MONITOR, 32'h02);
    $display("pll test done");
  endtask

  task t_ext;
    wr(`OFS_OSC_EN, 32'h09);
    uw(`OFS_MONITOR, 32'h03);
    sleep_stop <= 1'b1;
    ext_stopped <= 1'b1;
    repeat (10) @(posedge pclk);
    check(osc_enable, 5'h09);
    sleep_stop <= 1'b0;
    repeat (5) @(posedge pclk);
    check(osc_enable, 5'h01);
    check(nmi_cnt, 1);
    rd(`OFS_MONITOR, 32'h03);
    ext_stopped <= 1'b0;
    $display("external failure test done");
  endtask

  task t_loop;
    dref <= 4'hf;
    wr(`OFS_DFLL0_CFG, 32'h1);
    repeat (45) @(posedge pclk);
    check(cal_2m, 7'h41);
    sleep_stop <= 1'b1;
    repeat (100) @(posedge pclk);
    check(cal_2m, 7'h41);
    sleep_stop <= 1'b0;
    wr(`OFS_DFLL0_CFG, 32'h0);
    wr(`OFS_DFLL0_CAL, 32'h23);
    repeat (2) @(posedge pclk);
    check(cal_2m, 7'h23);
    rd(`OFS_DFLL0_CAL, 32'h07a1_0023);
    // Tiny compare value makes the fast loop see its oscillator as fast
    wr(`OFS_DFLL0_CAL + `FREQ_LOCK_CALIBRATOR_STRIDE, 32'h0001_0040);
    wr(`OFS_DFLL0_CFG + `FREQ_LOCK_CALIBRATOR_STRIDE, 32'h7);
    repeat (45) @(posedge pclk);
    check(cal_32m, 7'h3f);
    dref <= 4'h0;
    $display("calibration test done");
  endtask

  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_switch;
    t_prescale;
    t_pll;
    t_ext;
    t_loop;
    give_verdict;
  end
endmodule // testbench
